// *** src/ptcs_map.svh ***
// Purpose: Constants for the timer, counter and sequencer bank
// Assumes: 16-bit register port with word addresses
// Notes:   Included by the package and by the modules
`ifndef PTCS_MAP_SVH
`define PTCS_MAP_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define PTCS_NUM_TIMERS   64
`define PTCS_NUM_CTRS     64
`define PTCS_NUM_SEQ      8
`define PTCS_SEQ_STEPS    32
`define PTCS_WORD_W       16
`define PTCS_IDX_W        6
`define PTCS_ADDR_W       9

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PTCS_TICK_NS      100000000
`define PTCS_CLK_NS       10

// ----------------------------------------------------------------------
// Register map (word addresses) and reset values
// ----------------------------------------------------------------------
`define PTCS_TPV_BASE     9'h000
`define PTCS_TSV_BASE     9'h040
`define PTCS_CPV_BASE     9'h080
`define PTCS_CSV_BASE     9'h0c0
`define PTCS_TBIT_BASE    9'h100
`define PTCS_CBIT_BASE    9'h104
`define PTCS_SEQ_BASE     9'h108
`define PTCS_BANK_SIZE    9'h040
`define PTCS_BIT_SIZE     9'h004
`define PTCS_SEQ_SIZE     9'h010
`define PTCS_PV_RESET     16'h0000
`define PTCS_SV_RESET     16'h0000
`define PTCS_ONE          16'h0001

`endif

// *** src/ptcs_pkg.sv ***
// Purpose: Shared types for the timer, counter and sequencer bank
// Assumes: ptcs_map.svh gives the widths
// Notes:   Region enum drives the register decode
`include "ptcs_map.svh"

package ptcs_pkg;

   typedef logic [`PTCS_WORD_W-1:0] ptcs_word_t;
   typedef logic [`PTCS_IDX_W-1:0]  ptcs_idx_t;
   typedef logic [`PTCS_ADDR_W-1:0] ptcs_addr_t;

   typedef enum logic [2:0] {
      rg_none,
      rg_tpv,
      rg_tsv,
      rg_cpv,
      rg_csv,
      rg_tbit,
      rg_cbit,
      rg_seq
   } ptcs_region_e;

endpackage : ptcs_pkg

// *** src/ptcs_tick_gen.sv ***
// Purpose: Single timebase producing the 0.1 s tick enable
// Assumes: One clock; tick is a one-cycle pulse
// Notes:   TICK_CYCLES may be shortened for simulation
`timescale 1ns/1ns
`include "ptcs_map.svh"

module ptcs_tick_gen
   import ptcs_pkg::*;
#(
   parameter int TICK_CYCLES = `PTCS_TICK_NS / `PTCS_CLK_NS
) (
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   output logic      tick_o
);

   localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             tick_r;
   logic             tick_nxt;

   // ----------------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------------
   // one shared tick
   always_comb begin
      tick_nxt = (cnt_r == LAST);
      cnt_nxt  = tick_nxt ? '0 : cnt_r + CNT_W'(1);
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

   property p_tick_single;
      @(posedge core_clk_i) disable iff (!resetn_i)
      tick_o && (TICK_CYCLES > 1) |=> !tick_o;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("tick lasted more than one cycle");

endmodule : ptcs_tick_gen

// *** src/ptcs_timer_bank.sv ***
// Purpose: Bank of delay timers counting down on the shared tick
// Assumes: Coils come from logic on the same clock
// Notes:   Read port is a mux over the stored values
`timescale 1ns/1ns
`include "ptcs_map.svh"

module ptcs_timer_bank
   import ptcs_pkg::*;
#(
   parameter int NUM = `PTCS_NUM_TIMERS
) (
   input  wire logic           core_clk_i,
   input  wire logic           resetn_i,
   input  wire logic           tick_i,
   input  wire logic [NUM-1:0] coil_i,
   input  wire logic           wr_pv_i,
   input  wire logic           wr_sv_i,
   input  wire ptcs_idx_t      wr_idx_i,
   input  wire ptcs_word_t     wr_data_i,
   input  wire ptcs_idx_t      rd_idx_i,
   output ptcs_word_t          rd_pv_o,
   output ptcs_word_t          rd_sv_o,
   output logic [NUM-1:0]      contact_o
);

   ptcs_word_t     pv_r   [NUM];
   ptcs_word_t     pv_nxt [NUM];
   ptcs_word_t     sv_r   [NUM];
   ptcs_word_t     sv_nxt [NUM];
   logic [NUM-1:0] run_r;
   logic [NUM-1:0] run_nxt;
   logic [NUM-1:0] done_r;
   logic [NUM-1:0] done_nxt;
   logic [NUM-1:0] coil_q_r;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   always_comb begin
      pv_nxt   = pv_r;
      sv_nxt   = sv_r;
      run_nxt  = run_r;
      done_nxt = done_r;
      for (int i = 0; i < NUM; i++) begin
         if (coil_i[i] && !coil_q_r[i]) begin
            pv_nxt[i]   = sv_r[i];
            run_nxt[i]  = (sv_r[i] != `PTCS_PV_RESET);
            done_nxt[i] = (sv_r[i] == `PTCS_PV_RESET);
         end else if (!coil_i[i] && coil_q_r[i]) begin
            run_nxt[i]  = 1'b0;
            done_nxt[i] = 1'b0;
         end else if (tick_i && run_r[i]) begin
            pv_nxt[i] = pv_r[i] - `PTCS_ONE;
            if (pv_r[i] == `PTCS_ONE) begin
               run_nxt[i]  = 1'b0;
               done_nxt[i] = 1'b1;
            end
         end
      end
      if (wr_pv_i) begin
         pv_nxt[wr_idx_i]   = wr_data_i;
         run_nxt[wr_idx_i]  = (wr_data_i != `PTCS_PV_RESET);
         done_nxt[wr_idx_i] = 1'b0;
      end
      if (wr_sv_i) begin
         sv_nxt[wr_idx_i] = wr_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NUM; i++) begin
            pv_r[i] <= `PTCS_PV_RESET;
            sv_r[i] <= `PTCS_SV_RESET;
         end
         run_r    <= '0;
         done_r   <= '0;
         coil_q_r <= '0;
      end else begin
         pv_r     <= pv_nxt;
         sv_r     <= sv_nxt;
         run_r    <= run_nxt;
         done_r   <= done_nxt;
         coil_q_r <= coil_i;
      end
   end

   assign rd_pv_o   = pv_r[rd_idx_i];
   assign rd_sv_o   = sv_r[rd_idx_i];
   assign contact_o = done_r;

   property p_coil_drop;
      @(posedge core_clk_i) disable iff (!resetn_i)
      !coil_i[0] && coil_q_r[0] && !(wr_pv_i && wr_idx_i == '0) |=> !contact_o[0];
   endproperty
   a_coil_drop: assert property (p_coil_drop) else $error("timer contact held after coil drop");

endmodule : ptcs_timer_bank

// *** src/ptcs_bank.sv ***
// Purpose: Timer, counter and sequencer bank with register port
// Assumes: Coils and commands come from ladder logic on core_clk_i
// Notes:   Counters 1 to 8 double as step sequencers
`timescale 1ns/1ns
`include "ptcs_map.svh"

module ptcs_bank
   import ptcs_pkg::*;
#(
   parameter int NUM_TIMERS  = `PTCS_NUM_TIMERS,
   parameter int NUM_CTRS    = `PTCS_NUM_CTRS,
   parameter int NUM_SEQ     = `PTCS_NUM_SEQ,
   parameter int SEQ_STEPS   = `PTCS_SEQ_STEPS,
   parameter int TICK_CYCLES = `PTCS_TICK_NS / `PTCS_CLK_NS
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       resetn_i,
   input  wire logic [NUM_TIMERS-1:0]      timer_coil_i,
   input  wire logic [NUM_CTRS-1:0]        counter_coil_i,
   input  wire ptcs_idx_t                  cmd_idx_i,
   input  wire logic                       count_up_op_i,
   input  wire logic                       step_advance_i,
   input  wire logic                       count_down_op_i,
   input  wire logic                       counter_clear_i,
   input  wire logic                       step_deactivate_i,
   input  wire logic                       step_load_i,
   input  wire ptcs_word_t                 step_load_value_i,
   input  wire ptcs_addr_t                 reg_addr_i,
   input  wire ptcs_word_t                 reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output ptcs_word_t                      reg_rdata_o,
   output logic [NUM_TIMERS-1:0]           timer_contact_o,
   output logic [NUM_CTRS-1:0]             counter_contact_o,
   output logic [NUM_SEQ*SEQ_STEPS-1:0]    step_decode_contact_o
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic ptcs_region_e region(input ptcs_addr_t a);
      if (a >= `PTCS_TPV_BASE && a < `PTCS_TPV_BASE + `PTCS_BANK_SIZE) begin
         region = rg_tpv;
      end else if (a >= `PTCS_TSV_BASE && a < `PTCS_TSV_BASE + `PTCS_BANK_SIZE) begin
         region = rg_tsv;
      end else if (a >= `PTCS_CPV_BASE && a < `PTCS_CPV_BASE + `PTCS_BANK_SIZE) begin
         region = rg_cpv;
      end else if (a >= `PTCS_CSV_BASE && a < `PTCS_CSV_BASE + `PTCS_BANK_SIZE) begin
         region = rg_csv;
      end else if (a >= `PTCS_TBIT_BASE && a < `PTCS_TBIT_BASE + `PTCS_BIT_SIZE) begin
         region = rg_tbit;
      end else if (a >= `PTCS_CBIT_BASE && a < `PTCS_CBIT_BASE + `PTCS_BIT_SIZE) begin
         region = rg_cbit;
      end else if (a >= `PTCS_SEQ_BASE && a < `PTCS_SEQ_BASE + `PTCS_SEQ_SIZE) begin
         region = rg_seq;
      end else begin
         region = rg_none;
      end
   endfunction : region

   // Count one down; an idle counter loads limit minus one first
   function automatic ptcs_word_t count_down(input ptcs_word_t pv, input ptcs_word_t sv, input logic act);
      if (!act) begin
         count_down = sv - `PTCS_ONE;
      end else if (pv != `PTCS_PV_RESET) begin
         count_down = pv - `PTCS_ONE;
      end else begin
         count_down = pv;
      end
   endfunction : count_down

   // ----------------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------------
   ptcs_region_e  reg_region;
   ptcs_idx_t     reg_idx;
   logic          tick;
   ptcs_word_t    tmr_rd_pv;
   ptcs_word_t    tmr_rd_sv;

   assign reg_region = region(reg_addr_i);
   assign reg_idx    = reg_addr_i[`PTCS_IDX_W-1:0];

   ptcs_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .tick_o     (tick)
   );

   ptcs_timer_bank #(
      .NUM (NUM_TIMERS)
   ) u_timers (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .tick_i     (tick),
      .coil_i     (timer_coil_i),
      .wr_pv_i    (reg_wr_i && reg_region == rg_tpv),
      .wr_sv_i    (reg_wr_i && reg_region == rg_tsv),
      .wr_idx_i   (reg_idx),
      .wr_data_i  (reg_wdata_i),
      .rd_idx_i   (reg_idx),
      .rd_pv_o    (tmr_rd_pv),
      .rd_sv_o    (tmr_rd_sv),
      .contact_o  (timer_contact_o)
   );

   // ----------------------------------------------------------------------
   // Counters and sequencers
   // ----------------------------------------------------------------------
   ptcs_word_t          cpv_r    [NUM_CTRS];
   ptcs_word_t          cpv_nxt  [NUM_CTRS];
   ptcs_word_t          csv_r    [NUM_CTRS];
   ptcs_word_t          csv_nxt  [NUM_CTRS];
   logic [NUM_CTRS-1:0] cact_r;
   logic [NUM_CTRS-1:0] cact_nxt;
   logic [NUM_CTRS-1:0] ccoil_q_r;
   logic                up_cmd;
   logic                clr_cmd;
   logic                cmd_hit;

   assign up_cmd  = count_up_op_i || step_advance_i;
   assign clr_cmd = counter_clear_i || step_deactivate_i;
   assign cmd_hit = up_cmd || clr_cmd || step_load_i || count_down_op_i;

   always_comb begin
      cpv_nxt  = cpv_r;
      csv_nxt  = csv_r;
      cact_nxt = cact_r;
      for (int i = 0; i < NUM_CTRS; i++) begin
         if (counter_coil_i[i] && !ccoil_q_r[i]) begin
            cpv_nxt[i]  = count_down(cpv_r[i], csv_r[i], cact_r[i]);
            cact_nxt[i] = 1'b1;
         end
      end
      if (reg_wr_i && reg_region == rg_cpv) begin
         cpv_nxt[reg_idx]  = reg_wdata_i;
         cact_nxt[reg_idx] = 1'b1;
      end
      if (reg_wr_i && reg_region == rg_csv) begin
         csv_nxt[reg_idx] = reg_wdata_i;
      end
      if (clr_cmd) begin
         cpv_nxt[cmd_idx_i]  = `PTCS_PV_RESET;
         cact_nxt[cmd_idx_i] = 1'b0;
      end else if (step_load_i) begin
         cpv_nxt[cmd_idx_i]  = step_load_value_i;
         cact_nxt[cmd_idx_i] = 1'b1;
      end else if (up_cmd) begin
         cact_nxt[cmd_idx_i] = 1'b1;
         if (!cact_r[cmd_idx_i]) begin
            cpv_nxt[cmd_idx_i] = `PTCS_ONE;
         end else if (cpv_r[cmd_idx_i] == csv_r[cmd_idx_i]) begin
            cpv_nxt[cmd_idx_i] = `PTCS_PV_RESET;
         end else begin
            cpv_nxt[cmd_idx_i] = cpv_r[cmd_idx_i] + `PTCS_ONE;
         end
      end else if (count_down_op_i) begin
         cpv_nxt[cmd_idx_i]  = count_down(cpv_r[cmd_idx_i], csv_r[cmd_idx_i], cact_r[cmd_idx_i]);
         cact_nxt[cmd_idx_i] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NUM_CTRS; i++) begin
            cpv_r[i] <= `PTCS_PV_RESET;
            csv_r[i] <= `PTCS_SV_RESET;
         end
         cact_r    <= '0;
         ccoil_q_r <= '0;
      end else begin
         cpv_r     <= cpv_nxt;
         csv_r     <= csv_nxt;
         cact_r    <= cact_nxt;
         ccoil_q_r <= counter_coil_i;
      end
   end

   // ----------------------------------------------------------------------
   // Contacts
   // ----------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_CTRS; i++) begin
         counter_contact_o[i] = cact_r[i] && (cpv_r[i] == `PTCS_PV_RESET);
      end
      for (int n = 0; n < NUM_SEQ; n++) begin
         for (int x = 0; x < SEQ_STEPS; x++) begin
            step_decode_contact_o[n*SEQ_STEPS+x] = cact_r[n] && (cpv_r[n] == `PTCS_WORD_W'(x));
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------------
   ptcs_word_t rdata_r;
   ptcs_word_t rdata_nxt;
   ptcs_addr_t seq_off;

   // Step decode words are numbered from the start of their block
   assign seq_off = reg_addr_i - `PTCS_SEQ_BASE;

   always_comb begin
      rdata_nxt = '0;
      if (reg_rd_i) begin
         if (reg_region == rg_tpv) begin
            rdata_nxt = tmr_rd_pv;
         end else if (reg_region == rg_tsv) begin
            rdata_nxt = tmr_rd_sv;
         end else if (reg_region == rg_cpv) begin
            rdata_nxt = cpv_r[reg_idx];
         end else if (reg_region == rg_csv) begin
            rdata_nxt = csv_r[reg_idx];
         end else if (reg_region == rg_tbit) begin
            rdata_nxt = timer_contact_o[reg_addr_i[1:0]*`PTCS_WORD_W +: `PTCS_WORD_W];
         end else if (reg_region == rg_cbit) begin
            rdata_nxt = counter_contact_o[reg_addr_i[1:0]*`PTCS_WORD_W +: `PTCS_WORD_W];
         end else if (reg_region == rg_seq) begin
            rdata_nxt = step_decode_contact_o[seq_off[3:0]*`PTCS_WORD_W +: `PTCS_WORD_W];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_clear_wins;
      @(posedge core_clk_i) disable iff (!resetn_i)
      clr_cmd |=> !cact_r[$past(cmd_idx_i)] && !counter_contact_o[$past(cmd_idx_i)];
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("clear did not deactivate counter");

   property p_load_step;
      @(posedge core_clk_i) disable iff (!resetn_i)
      step_load_i && !clr_cmd |=> cact_r[$past(cmd_idx_i)] && cpv_r[$past(cmd_idx_i)] == $past(step_load_value_i);
   endproperty
   a_load_step: assert property (p_load_step) else $error("step load not applied");

   property p_first_advance;
      @(posedge core_clk_i) disable iff (!resetn_i)
      up_cmd && !clr_cmd && !step_load_i && !cact_r[cmd_idx_i] |=> cpv_r[$past(cmd_idx_i)] == `PTCS_ONE;
   endproperty
   a_first_advance: assert property (p_first_advance) else $error("first advance not step one");

   property p_advance_inc;
      @(posedge core_clk_i) disable iff (!resetn_i)
      up_cmd && !clr_cmd && !step_load_i && cact_r[cmd_idx_i] && cpv_r[cmd_idx_i] != csv_r[cmd_idx_i]
      |=> cpv_r[$past(cmd_idx_i)] == $past(cpv_r[cmd_idx_i]) + `PTCS_ONE;
   endproperty
   a_advance_inc: assert property (p_advance_inc) else $error("advance did not add one");

   property p_wrap;
      @(posedge core_clk_i) disable iff (!resetn_i)
      up_cmd && !clr_cmd && !step_load_i && cact_r[cmd_idx_i] && cpv_r[cmd_idx_i] == csv_r[cmd_idx_i]
      |=> counter_contact_o[$past(cmd_idx_i)];
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap to step zero at limit");

   property p_step_back;
      @(posedge core_clk_i) disable iff (!resetn_i)
      count_down_op_i && !up_cmd && !clr_cmd && !step_load_i && cact_r[cmd_idx_i] && cpv_r[cmd_idx_i] != '0
      |=> cpv_r[$past(cmd_idx_i)] == $past(cpv_r[cmd_idx_i]) - `PTCS_ONE;
   endproperty
   a_step_back: assert property (p_step_back) else $error("down count did not step back");

   property p_decode_off;
      @(posedge core_clk_i) disable iff (!resetn_i)
      clr_cmd && cmd_idx_i < NUM_SEQ |=> step_decode_contact_o[$past(cmd_idx_i[2:0])*SEQ_STEPS +: SEQ_STEPS] == '0;
   endproperty
   a_decode_off: assert property (p_decode_off) else $error("decode contact on while inactive");

   property p_pv_write;
      @(posedge core_clk_i) disable iff (!resetn_i)
      reg_wr_i && reg_region == rg_cpv && !(cmd_hit && cmd_idx_i == reg_idx)
      |=> cpv_r[$past(reg_idx)] == $past(reg_wdata_i);
   endproperty
   a_pv_write: assert property (p_pv_write) else $error("counter value write not immediate");

   property p_first_coil;
      @(posedge core_clk_i) disable iff (!resetn_i)
      counter_coil_i[NUM_CTRS-1] && !ccoil_q_r[NUM_CTRS-1] && !cact_r[NUM_CTRS-1] && !cmd_hit && !reg_wr_i
      |=> cpv_r[NUM_CTRS-1] == $past(csv_r[NUM_CTRS-1]) - `PTCS_ONE;
   endproperty
   a_first_coil: assert property (p_first_coil) else $error("first coil did not load limit minus one");

endmodule : ptcs_bank

// *** tb/ptcs_bank_bench.sv ***
// Purpose: Self-checking bench for the timer, counter and sequencer bank
// Assumes: Short tick period; register port and command strobes driven by tasks
// Notes:   Expected values derive from the limits and steps written here
`timescale 1ns/1ns
`include "ptcs_map.svh"

module ptcs_bank_bench
   import ptcs_pkg::*;
;
   localparam int T = 8;
   logic                 core_clk_i, resetn_i, reg_wr_i, reg_rd_i;
   logic [63:0]          timer_coil_i, counter_coil_i, timer_contact_o, counter_contact_o;
   logic [255:0]         step_decode_contact_o;
   logic [5:0]           s;
   ptcs_idx_t            cmd_idx_i;
   ptcs_word_t           step_load_value_i, reg_wdata_i, reg_rdata_o;
   ptcs_addr_t           reg_addr_i;
   int                   mismatches, comparisons;

   ptcs_bank #(.TICK_CYCLES(T)) DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .timer_coil_i(timer_coil_i), .counter_coil_i(counter_coil_i), .cmd_idx_i(cmd_idx_i),
      .count_up_op_i(s[0]), .step_advance_i(s[1]), .count_down_op_i(s[2]), .counter_clear_i(s[3]),
      .step_deactivate_i(s[4]), .step_load_i(s[5]), .step_load_value_i(step_load_value_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .timer_contact_o(timer_contact_o),
      .counter_contact_o(counter_contact_o), .step_decode_contact_o(step_decode_contact_o));

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   initial begin
      #200000;
      mismatches = mismatches + 1;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk_w(input string n, input ptcs_word_t e, input ptcs_word_t g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk_w

   task automatic chk_b(input string n, input logic e, input logic g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask : chk_b

   task automatic wr(input ptcs_addr_t a, input ptcs_word_t d);
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input ptcs_addr_t a, input ptcs_word_t e);
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk_w($sformatf("rdata@%h", a), e, reg_rdata_o);
   endtask : rd

   // Strobe set: bit0 up, 1 advance, 2 down, 3 clear, 4 deactivate, 5 load
   task automatic cmd(input logic [5:0] m, input ptcs_idx_t i, input ptcs_word_t v);
      @(posedge core_clk_i);
      s                 <= m;
      cmd_idx_i         <= i;
      step_load_value_i <= v;
      @(posedge core_clk_i);
      s                 <= 6'h00;
      #1;
   endtask : cmd

   task automatic ccoil(input int b, input logic v);
      @(posedge core_clk_i);
      counter_coil_i[b] <= v;
      @(posedge core_clk_i);
      #1;
   endtask : ccoil

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      mismatches = 0; comparisons = 0; resetn_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
      timer_coil_i = '0; counter_coil_i = '0; s = 6'h00; cmd_idx_i = '0;
      step_load_value_i = '0; reg_wdata_i = '0; reg_addr_i = '0;
      repeat (4) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd(9'h0c0, 16'h0000);
      rd(9'h1ff, 16'h0000);
      $display("test reset done");
      wr(9'h040, 16'h0003);
      @(posedge core_clk_i);
      timer_coil_i[0] <= 1'b1;
      repeat (2*T) @(posedge core_clk_i);
      #1 chk_b("timer1 early", 1'b0, timer_contact_o[0]);
      repeat (T+2) @(posedge core_clk_i);
      #1 chk_b("timer1 expired", 1'b1, timer_contact_o[0]);
      rd(9'h100, 16'h0001);
      timer_coil_i[0] <= 1'b0;
      @(posedge core_clk_i);
      #1 chk_b("timer1 dropped", 1'b0, timer_contact_o[0]);
      wr(9'h001, 16'h0002);
      rd(9'h001, 16'h0002);
      repeat (T-2) @(posedge core_clk_i);
      #1 chk_b("timer2 early", 1'b0, timer_contact_o[1]);
      repeat (T+2) @(posedge core_clk_i);
      #1 chk_b("timer2 expired", 1'b1, timer_contact_o[1]);
      rd(9'h040, 16'h0003);
      $display("test timers done");
      wr(9'h0c2, 16'h0003);
      ccoil(2, 1'b1);
      rd(9'h082, 16'h0002);
      ccoil(2, 1'b0);
      ccoil(2, 1'b1);
      rd(9'h082, 16'h0001);
      ccoil(2, 1'b0);
      ccoil(2, 1'b1);
      ccoil(2, 1'b0);
      chk_b("ctr3 zero", 1'b1, counter_contact_o[2]);
      rd(9'h104, 16'h0004);
      cmd(6'h08, 6'd2, 16'h0000);
      chk_b("ctr3 cleared", 1'b0, counter_contact_o[2]);
      wr(9'h082, 16'h0005);
      wr(9'h082, 16'h0004);
      rd(9'h082, 16'h0004);
      ccoil(63, 1'b1);
      rd(9'h0bf, 16'hffff);
      $display("test counters done");
      wr(9'h0c1, 16'h0002);
      cmd(6'h02, 6'd1, 16'h0000);
      chk_b("seq2 step1", 1'b1, step_decode_contact_o[33]);
      cmd(6'h02, 6'd1, 16'h0000);
      chk_b("seq2 step2", 1'b1, step_decode_contact_o[34]);
      cmd(6'h02, 6'd1, 16'h0000);
      chk_b("seq2 wrap", 1'b1, step_decode_contact_o[32]);
      chk_b("seq2 done", 1'b1, counter_contact_o[1]);
      cmd(6'h01, 6'd1, 16'h0000);
      chk_b("seq2 up", 1'b1, step_decode_contact_o[33]);
      chk_b("seq2 done off", 1'b0, counter_contact_o[1]);
      cmd(6'h04, 6'd1, 16'h0000);
      chk_b("seq2 back", 1'b1, step_decode_contact_o[32]);
      cmd(6'h10, 6'd1, 16'h0000);
      chk_w("seq2 idle", 16'h0000, step_decode_contact_o[47:32]);
      cmd(6'h20, 6'd1, 16'h001f);
      rd(9'h10b, 16'h8000);
      cmd(6'h20, 6'd1, 16'h0028);
      chk_w("seq2 hi lo", 16'h0000, step_decode_contact_o[47:32]);
      chk_w("seq2 hi hi", 16'h0000, step_decode_contact_o[63:48]);
      cmd(6'h28, 6'd1, 16'h0003);
      chk_b("seq2 clear wins", 1'b0, step_decode_contact_o[35]);
      cmd(6'h21, 6'd1, 16'h0004);
      chk_b("seq2 load wins", 1'b1, step_decode_contact_o[36]);
      wr(9'h081, 16'h0003);
      chk_b("seq2 written", 1'b1, step_decode_contact_o[35]);
      $display("test sequencers done");
      print_verdict();
   end

endmodule : ptcs_bank_bench
